// ### hw/id_and_freq_offset_regs.sv
// Identification and oscillator trim register bank.
// Assumes a host that strobes one byte access per cycle, at most.
//
// Summary of operation
// [RL1] Ready bit low until initialisation ends
// [RL2] Part identifier read-only byte, host never writes
// [RL3] Silicon revision read-only byte, host never writes
// [RL4] Trim word: 32-bit signed, four bytes
// [RL5] One trim word feeds all four synthesizers
// [RL6] Host: positive trim for slow oscillator
// [RL7] Host computes trim from oscillator inaccuracy
// [RL8] Host keeps default for standard master clocks
// [RL9] Host keeps trim within five percent
// [RL10] Host writes spur setting after trim writes
// [RL11] Spur write starts 85 ms reconfiguration
// [RL12] Writes to identity registers change nothing
//
// The strobed register port was chosen for this implementation.
module id_and_freq_offset_regs
  import trim_regs_pkg::*;
#(
  parameter logic [4:0]  FAMILY_ID   = 5'h0a,       // Arbitrary value
  parameter logic [7:0]  PART_ID     = 8'h3c,       // Arbitrary value
  parameter logic [7:0]  REVISION_ID = 8'h01,       // Arbitrary value
  parameter int          INIT_CNT    = INIT_CYCLES, // Init length
  parameter int          RECONF_CNT  = RECONF_CYCLES // Reconfig length
)
(
  input  wire logic                          SYS_CLK, // System clock
  input  wire logic                          RST_N,   // Sync reset, low
  input  wire logic [trim_regs_pkg::ADDR_W-1:0] ADDR, // Byte address
  input  wire logic [trim_regs_pkg::DATA_W-1:0] WDATA,// Write data
  input  wire logic                          WR,      // Write strobe
  input  wire logic                          RD,      // Read strobe
  output logic [trim_regs_pkg::DATA_W-1:0]   RDATA,   // Read data
  output logic [trim_regs_pkg::NUM_SYNTH-1:0][trim_regs_pkg::TRIM_W-1:0]
                                             SYNTH_TRIM, // Per synth
  output logic [trim_regs_pkg::DATA_W-1:0]   SPUR_SETTING, // Spur value
  output logic                               RECONFIG_BUSY, // Reconfig
  output logic                               READY          // Init done
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations
  localparam int ICW = $clog2(INIT_CNT + 1);        // Init counter width

  typedef enum logic [1:0] {ST_INIT, ST_RUN} init_e; // Startup states

  bus_req_s               req;                      // Bundled request
  init_e                  state_r;                  // Startup state
  logic [ICW-1:0]         init_cnt_r;               // Init countdown
  logic [TRIM_W-1:0]      trim_r;                   // Trim word
  logic [DATA_W-1:0]      spur_r;                   // Spur setting
  logic [DATA_W-1:0]      rd_nxt;                   // Read mux
  logic                   spur_wr;                  // Spur write pulse
  logic                   busy;                     // Reconfig active
  logic [1:0]             trim_idx;                 // Trim byte index
  logic                   trim_hit;                 // Trim address hit

  assign req = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};
  assign trim_hit = (req.addr >= OFS_TRIM0) && (req.addr <= OFS_TRIM3);
  assign trim_idx = 2'(req.addr - OFS_TRIM0);
  assign spur_wr = req.wr && (req.addr == OFS_SPUR);

  //////////////////////////////////////////////////////////////////////////
  // Startup sequencer: ready flag after init count
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      state_r    <= ST_INIT;
      init_cnt_r <= ICW'(INIT_CNT);
    end
    else
    begin
      case (state_r)
        ST_INIT:
        begin
          // Count down, then release the host
          if (init_cnt_r <= ICW'(1))
            state_r <= ST_RUN;                      // [RL1]
          else
            init_cnt_r <= init_cnt_r - 1'b1;
        end
        ST_RUN:
          state_r <= ST_RUN;
        default:
          state_r <= ST_INIT;
      endcase
    end
  end

  // Ready output straight from a flop
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      READY <= 1'b0;
    else
      READY <= (state_r == ST_RUN);                 // [RL1]
  end

  //////////////////////////////////////////////////////////////////////////
  // Trim word, big-endian across four byte addresses
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      trim_r <= TRIM_RESET;
    else if (req.wr && trim_hit)
    begin
      // Lowest address holds the most significant byte
      case (trim_idx)                               // [RL4]
        2'h0:    trim_r[31:24] <= req.wdata;
        2'h1:    trim_r[23:16] <= req.wdata;
        2'h2:    trim_r[15:8]  <= req.wdata;
        2'h3:    trim_r[7:0]   <= req.wdata;
        default: trim_r        <= trim_r;
      endcase
    end
  end

  // Spur setting; writes restart reconfiguration
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      spur_r <= SPUR_RESET;
    else if (spur_wr)
      spur_r <= req.wdata;                          // [RL11]
  end

  // Reconfiguration period timer
  busy_timer #(
    .CYCLES (RECONF_CNT)
  ) u_reconf (
    .clk    (SYS_CLK),
    .rst_n  (RST_N),
    .start  (spur_wr),                              // [RL11]
    .busy   (busy)
  );

  //////////////////////////////////////////////////////////////////////////
  // Outputs to synthesizers, one trim word fanned out
  genvar g;
  generate
    for (g = 0; g < NUM_SYNTH; g++)
    begin : g_synth
      always_ff @(posedge SYS_CLK)
      begin
        if (!RST_N)
          SYNTH_TRIM[g] <= TRIM_RESET;
        else
          SYNTH_TRIM[g] <= trim_r;                  // [RL5]
      end
    end
  endgenerate

  // Spur and busy outputs registered
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      SPUR_SETTING  <= SPUR_RESET;
      RECONFIG_BUSY <= 1'b0;
    end
    else
    begin
      SPUR_SETTING  <= spur_r;
      RECONFIG_BUSY <= busy || spur_wr;             // [RL11]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read mux; identity registers ignore writes
  always_comb
  begin
    rd_nxt = UNMAPPED_RD;
    if (req.addr == OFS_READY)
      rd_nxt = {(state_r == ST_RUN), READY_RSVD, FAMILY_ID}; // [RL1]
    else if (req.addr == OFS_PART_ID)
      rd_nxt = PART_ID;                             // [RL2] [RL12]
    else if (req.addr == OFS_REVISION)
      rd_nxt = REVISION_ID;                         // [RL3] [RL12]
    else if (trim_hit)
    begin
      case (trim_idx)
        2'h0:    rd_nxt = trim_r[31:24];            // [RL4]
        2'h1:    rd_nxt = trim_r[23:16];
        2'h2:    rd_nxt = trim_r[15:8];
        default: rd_nxt = trim_r[7:0];
      endcase
    end
    else if (req.addr == OFS_SPUR)
      rd_nxt = spur_r;
  end

  // Read data valid the cycle after the strobe only
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      RDATA <= '0;
    else if (req.rd)
      RDATA <= rd_nxt;
    else
      RDATA <= '0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_ready_low_init;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (state_r == ST_INIT) |=> !READY;
  endproperty
  a_ready_low_init: assert property (p_ready_low_init) // [RL1]
    else $error("Ready high during initialisation");

  property p_ready_stays;
    @(posedge SYS_CLK) disable iff (!RST_N)
    READY |=> READY;
  endproperty
  a_ready_stays: assert property (p_ready_stays) // [RL1]
    else $error("Ready dropped without reset");

  property p_part_id_read;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (RD && ADDR == OFS_PART_ID) |=> (RDATA == PART_ID);
  endproperty
  a_part_id_read: assert property (p_part_id_read) // [RL2]
    else $error("Part identifier read wrong");

  property p_rev_read;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (RD && ADDR == OFS_REVISION) |=> (RDATA == REVISION_ID);
  endproperty
  a_rev_read: assert property (p_rev_read) // [RL3]
    else $error("Silicon revision read wrong");

  property p_trim_msb;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (WR && ADDR == OFS_TRIM0) |=> ##1
      (SYNTH_TRIM[0][31:24] == $past(WDATA, 2));
  endproperty
  a_trim_msb: assert property (p_trim_msb) // [RL4]
    else $error("Trim high byte not updated");

  property p_all_synth;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (SYNTH_TRIM[0] == SYNTH_TRIM[1]) && (SYNTH_TRIM[1] == SYNTH_TRIM[2])
      && (SYNTH_TRIM[2] == SYNTH_TRIM[3]);
  endproperty
  a_all_synth: assert property (p_all_synth) // [RL5]
    else $error("Synthesizer trims differ");

  property p_reconf_busy;
    @(posedge SYS_CLK) disable iff (!RST_N)
    spur_wr |=> RECONFIG_BUSY [*8];
  endproperty
  a_reconf_busy: assert property (p_reconf_busy) // [RL11]
    else $error("Reconfiguration not flagged");

  property p_id_wr_inert;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (WR && ADDR <= OFS_REVISION) |=> $stable(trim_r) && $stable(spur_r);
  endproperty
  a_id_wr_inert: assert property (p_id_wr_inert) // [RL12]
    else $error("Identity write disturbed state");

  // Ready bit and READY both follow the state one edge later, so a
  // read of the readiness register must agree with the pin
  property p_ready_reg_read;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (RD && ADDR == OFS_READY) |=> (RDATA == {READY, READY_RSVD, FAMILY_ID});
  endproperty
  a_ready_reg_read: assert property (p_ready_reg_read) // [RL1]
    else $error("Readiness register read wrong");

  // Read-back of the top trim byte matches what the synthesizers get
  property p_trim_rd_msb;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (RD && ADDR == OFS_TRIM0) |=> (RDATA == SYNTH_TRIM[0][31:24]);
  endproperty
  a_trim_rd_msb: assert property (p_trim_rd_msb) // [RL4]
    else $error("Trim high byte read-back wrong");

  property p_trim_lsb;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (WR && ADDR == OFS_TRIM3) |=> ##1
      (SYNTH_TRIM[3][7:0] == $past(WDATA, 2));
  endproperty
  a_trim_lsb: assert property (p_trim_lsb) // [RL4] [RL5]
    else $error("Trim low byte not updated");

  // Spur value reaches its output two edges after the write
  property p_spur_out;
    @(posedge SYS_CLK) disable iff (!RST_N)
    spur_wr |=> ##1 (SPUR_SETTING == $past(WDATA, 2));
  endproperty
  a_spur_out: assert property (p_spur_out) // [RL11]
    else $error("Spur setting not updated");

  // Busy flag drops one edge after the timer runs out, unless restarted
  property p_busy_ends;
    @(posedge SYS_CLK) disable iff (!RST_N)
    ($fell(busy) && !spur_wr) |=> !RECONFIG_BUSY;
  endproperty
  a_busy_ends: assert property (p_busy_ends) // [RL11]
    else $error("Reconfiguration flag held too long");

  c_ready: cover property (@(posedge SYS_CLK) $rose(READY));
  c_trim_wr: cover property (@(posedge SYS_CLK) WR && trim_hit);
  c_spur_wr: cover property (@(posedge SYS_CLK) spur_wr);
  c_reconf_end: cover property (@(posedge SYS_CLK) $fell(RECONFIG_BUSY));

endmodule : id_and_freq_offset_regs

// ### inc/trim_regs_pkg.sv
// Package for the identification and oscillator trim register bank.
// Assumes an 8-bit byte-wide register port with 11-bit byte addresses.
package trim_regs_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W = 11;                       // Byte address width
  localparam int DATA_W = 8;                        // Register data width
  localparam int TRIM_W = 32;                       // Trim word width
  localparam int NUM_SYNTH = 4;                     // Synthesizers trimmed

  //////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_READY    = 11'h000; // Readiness/family
  localparam logic [ADDR_W-1:0] OFS_PART_ID  = 11'h001; // Part identifier
  localparam logic [ADDR_W-1:0] OFS_REVISION = 11'h002; // Silicon revision
  localparam logic [ADDR_W-1:0] OFS_TRIM0    = 11'h00b; // Trim, MSB byte
  localparam logic [ADDR_W-1:0] OFS_TRIM3    = 11'h00e; // Trim, LSB byte
  localparam logic [ADDR_W-1:0] OFS_SPUR     = 11'h010; // Spur setting

  //////////////////////////////////////////////////////////////////////////
  // Field positions and values
  localparam int READY_BIT = 7;                     // Ready flag bit
  localparam logic [1:0] READY_RSVD = 2'h0;         // Bits 6:5
  localparam logic [TRIM_W-1:0] TRIM_RESET = 32'h046aaaab; // Trim default
  localparam logic [DATA_W-1:0] SPUR_RESET = 8'h00; // Spur default
  localparam logic [DATA_W-1:0] UNMAPPED_RD = 8'h00; // Unmapped read

  //////////////////////////////////////////////////////////////////////////
  // Timing at 100 MHz
  localparam int CLK_PERIOD_NS = 10;                // SYS_CLK period
  localparam int INIT_TIME_NS = 1000;               // Initialisation time
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;     // Rounded up
  localparam int RECONF_TIME_MS = 85;               // Reconfiguration time
  localparam int RECONF_CYCLES = (RECONF_TIME_MS * 1000000
                                 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  //////////////////////////////////////////////////////////////////////////
  // Bus request carrier
  typedef struct packed
  {
    logic              wr;                          // Write strobe
    logic              rd;                          // Read strobe
    logic [ADDR_W-1:0] addr;                        // Byte address
    logic [DATA_W-1:0] wdata;                       // Write data
  } bus_req_s;

endpackage : trim_regs_pkg

// ### hw/busy_timer.sv
// Busy timer: loads on a start pulse and counts down to zero.
// Assumes one clock, synchronous active-low reset.
module busy_timer
#(
  parameter int CYCLES = 16                         // Busy length in cycles
)
(
  input  wire logic clk,                            // System clock
  input  wire logic rst_n,                          // Sync reset, low
  input  wire logic start,                          // Begin a busy period
  output logic      busy                            // Counting
);
  localparam int CW = $clog2(CYCLES + 1);           // Counter width
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);     // Load value

  logic [CW-1:0] count_r;                           // Cycles remaining

  // Load on start, else count down
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      count_r <= '0;
    else if (start)
      count_r <= LOAD;
    else if (count_r != '0)
      count_r <= count_r - 1'b1;
  end

  assign busy = (count_r != '0);

endmodule : busy_timer

// ### testbench/tb_id_and_freq_offset_regs.sv
// Self-checking bench for the identification and trim register bank.
// Assumes the bank samples its byte port on rising SYS_CLK edges.
module tb_id_and_freq_offset_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import trim_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Short counts keep the run brief; all values arbitrary
  localparam int         INIT_T   = 4;              // Init length
  localparam int         RECONF_T = 16;             // Reconfig length
  localparam logic [4:0] FAM      = 5'h15;          // Arbitrary family
  localparam logic [7:0] PID      = 8'h5a;          // Arbitrary part code
  localparam logic [7:0] REV      = 8'h07;          // Arbitrary revision

  typedef struct packed
  {
    logic              wr;                          // Write, else read
    logic [ADDR_W-1:0] addr;                        // Byte address
    logic [DATA_W-1:0] val;                         // Data or expected
  } row_s;

  logic                             SYS_CLK = 1'b0; // Clock
  logic                             RST_N = 1'b0;   // Reset, low
  logic                             WR = 1'b0;      // Write strobe
  logic                             RD = 1'b0;      // Read strobe
  logic [ADDR_W-1:0]                ADDR = '0;      // Address
  logic [DATA_W-1:0]                WDATA = '0;     // Write data
  logic [DATA_W-1:0]                RDATA;          // Read data
  logic [DATA_W-1:0]                SPUR_SETTING;   // Spur value
  logic [NUM_SYNTH-1:0][TRIM_W-1:0] SYNTH_TRIM;     // Trim outputs
  logic                             RECONFIG_BUSY;  // Reconfig busy
  logic                             READY;          // Init done
  int                               err_total = 0;  // Mismatches
  int                               samples_checked = 0; // Compares
  int                               n;              // Edge counter

  // Ordinary accesses, issued back to back
  row_s rows [19] = '{
    '{1'b0, OFS_PART_ID, PID}, '{1'b0, OFS_REVISION, REV},
    '{1'b1, OFS_PART_ID, 8'hff}, '{1'b0, OFS_PART_ID, PID},
    '{1'b1, OFS_REVISION, 8'h00}, '{1'b0, OFS_REVISION, REV},
    '{1'b1, OFS_READY, 8'h00}, '{1'b0, OFS_READY, {1'b1, READY_RSVD, FAM}},
    '{1'b0, 11'h00b, 8'h04}, '{1'b0, 11'h00c, 8'h6a},
    '{1'b0, 11'h00d, 8'haa}, '{1'b0, 11'h00e, 8'hab},
    '{1'b1, 11'h00b, 8'hfa}, '{1'b1, 11'h00c, 8'hfa},
    '{1'b1, 11'h00d, 8'hfa}, '{1'b1, 11'h00e, 8'hfb},
    '{1'b0, 11'h00d, 8'hfa}, '{1'b1, 11'h7ff, 8'h55},
    '{1'b0, 11'h7ff, 8'h00}};

  id_and_freq_offset_regs
  #(
    .FAMILY_ID   (FAM),
    .PART_ID     (PID),
    .REVISION_ID (REV),
    .INIT_CNT    (INIT_T),
    .RECONF_CNT  (RECONF_T)
  )
  dut_u
  (
    .SYS_CLK       (SYS_CLK),
    .RST_N         (RST_N),
    .ADDR          (ADDR),
    .WDATA         (WDATA),
    .WR            (WR),
    .RD            (RD),
    .RDATA         (RDATA),
    .SYNTH_TRIM    (SYNTH_TRIM),
    .SPUR_SETTING  (SPUR_SETTING),
    .RECONFIG_BUSY (RECONFIG_BUSY),
    .READY         (READY)
  );

  ////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial
  begin
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  // Compare a byte or word result
  task automatic chk_val(string nm, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_val

  // Compare a single flag
  task automatic chk_flag(string nm, logic exp, logic got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_flag

  // One access; strobes stay up so calls chain with no gap
  task automatic acc(logic w, logic [ADDR_W-1:0] a, logic [7:0] d);
    WR <= w;
    RD <= ~w;
    ADDR <= a;
    WDATA <= d;
    @(posedge SYS_CLK);
    #1;
    if (!w)
      chk_val("read data", d, RDATA);
  endtask : acc

  // Drop both strobes before the next edge
  task automatic idle();
    WR <= 1'b0;
    RD <= 1'b0;
  endtask : idle

  // Hold reset, release, probe early state and count edges to READY
  task automatic do_reset(int cycles);
    RST_N <= 1'b0;
    repeat (cycles) @(posedge SYS_CLK);
    #1;
    chk_val("trim after reset", TRIM_RESET, SYNTH_TRIM[0]);
    chk_val("spur after reset", SPUR_RESET, SPUR_SETTING);
    chk_flag("ready in reset", 1'b0, READY);
    RST_N <= 1'b1;
    acc(1'b0, OFS_READY, {1'b0, READY_RSVD, FAM});
    idle();
    n = 1;
    while (READY !== 1'b1 && n < 50)
    begin
      @(posedge SYS_CLK);
      #1;
      n++;
    end
    // Released count lands one or two edges past the init length
    chk_flag("ready delay", 1'b1, n >= INIT_T + 1 && n <= INIT_T + 2);
  endtask : do_reset

  // Report counts, print verdict, stop
  task automatic test_done();
    $display("Checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the fewer than a hundred cycles the tests need
  initial
  begin
    repeat (5000) @(posedge SYS_CLK);
    err_total++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    do_reset(16);
    @(posedge SYS_CLK);
    foreach (rows[i])
      acc(rows[i].wr, rows[i].addr, rows[i].val);
    idle();
    for (int s = 0; s < NUM_SYNTH; s++)
      chk_val("synth trim", 32'hfafafafb, SYNTH_TRIM[s]);
    // Trim lands two edges after the write strobe
    @(posedge SYS_CLK);
    // Small positive offset keeps the word well inside the legal span
    acc(1'b1, OFS_TRIM0, 8'h05);
    idle();
    chk_val("trim early", 32'hfafafafb, SYNTH_TRIM[3]);
    @(posedge SYS_CLK);
    #1;
    chk_val("trim msb", 32'h05fafafb, SYNTH_TRIM[3]);
    // Spur write after the trim change starts the busy period
    acc(1'b1, OFS_SPUR, 8'h81);
    idle();
    n = 0;
    while (RECONFIG_BUSY === 1'b1 && n < 100)
    begin
      @(posedge SYS_CLK);
      #1;
      n++;
    end
    chk_val("busy length", RECONF_T + 1, n);
    // Spur output is registered twice, so look once the window closes
    chk_val("spur value", 8'h81, SPUR_SETTING);
    // Second reset in mid-run restores the defaults
    do_reset(2);
    chk_val("trim restored", TRIM_RESET, SYNTH_TRIM[1]);
    test_done();
  end

endmodule : tb_id_and_freq_offset_regs
